// ===== verilog/sumc_pkg.sv
// constants for the two-channel supply undervoltage monitor
// assumes a 250 MHz system clock and a 32-bit AHB-Lite register bus
package sumc_pkg;

    // ************************************************
    // register offsets
    // ************************************************
    localparam logic [7:0] OFF_CTRL_A   = 8'h00;
    localparam logic [7:0] OFF_CTRL_B   = 8'h04;
    localparam logic [7:0] OFF_EVT_STAT = 8'h08;
    localparam logic [7:0] OFF_EVT_MASK = 8'h0C;

    // ************************************************
    // monitor control fields
    // ************************************************
    localparam int BIT_BELOW      = 7;
    localparam int BIT_RST_ALLOW  = 6;
    localparam int BIT_IRQ_ALLOW  = 5;
    localparam int BIT_EDGE       = 4;
    localparam int BIT_CODE_HI    = 3;
    localparam int BIT_CODE_LO    = 1;
    localparam int BIT_ENABLE     = 0;
    localparam logic [7:0] CTRL_WR_MASK = 8'h6F;
    localparam logic [7:0] CTRL_A_RST   = 8'h49;
    localparam logic [7:0] CTRL_B_RST   = 8'h06;
    localparam logic [1:0] EVT_MASK_RST = 2'h0;

    // ************************************************
    // threshold codes of monitor a
    // ************************************************
    localparam logic [2:0] CODE_A_2V0 = 3'h4;
    localparam logic [2:0] CODE_A_2V1 = 3'h5;

    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_PERIOD_PS  = 4000;
    localparam int DETECT_TIME_PS = 100000000;
    localparam int DETECT_CYCLES_DFLT =
        (DETECT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int DET_CNT_W = 15;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ===== verilog/sumc_top.sv
// two supply undervoltage monitors with AHB-Lite registers
// assumes comparator outputs are async levels, high when supply is low
`timescale 1ns/100ps
module sumc_top #(
    parameter int DETECT_CYCLES = sumc_pkg::DETECT_CYCLES_DFLT
) (
    // clock and reset
    input  wire  logic        ref_clk,
    input  wire  logic        sys_rst,
    // ahb-lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic              hreadyout,
    output logic [31:0]       hrdata,
    output logic              hresp,
    // analog comparator side
    input  wire  logic [1:0]  supplyBelowRaw,
    input  wire  logic [1:0]  irqEdgeChoice,
    output logic [1:0]        monitorEnable,
    output logic [5:0]        thresholdCode,
    // system side
    output logic              resetReq,
    output logic              nmiUndervoltageIrq,
    output logic              intLevel
);
    import sumc_pkg::*;

    // ************************************************
    // decode helpers
    // ************************************************
    function automatic logic codeValid(input int mon, input logic [2:0] code);
        codeValid = (mon != 0) || (code == CODE_A_2V0) || (code == CODE_A_2V1);
    endfunction

    function automatic logic [7:0] ctrlRst(input int mon);
        ctrlRst = (mon == 0) ? CTRL_A_RST : CTRL_B_RST;
    endfunction

    // ************************************************
    // bus slave
    // ************************************************
    logic [7:0]  ctrl [2];
    logic [1:0]  evtStat;
    logic [1:0]  evtMask;
    logic [1:0]  belowSync;
    logic [1:0]  evtHit;
    logic        wrPend;
    logic [7:0]  wrAddr;
    logic        accept;
    logic        rdStat;
    logic [7:0]  aOff;

    assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
    assign aOff = haddr[7:0];
    assign rdStat = accept && !hwrite && (aOff == OFF_EVT_STAT) && (haddr[31:8] == 24'h0);
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;

    function automatic logic [7:0] ctrlView(input int mon);
        logic [7:0] v;
        v = ctrl[mon] & CTRL_WR_MASK;
        v[BIT_BELOW] = belowSync[mon];
        v[BIT_EDGE] = irqEdgeChoice[mon];
        ctrlView = v;
    endfunction

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
        end else if (hready) begin
            wrPend <= accept && hwrite && (haddr[31:8] == 24'h0);
            wrAddr <= aOff;
        end
    end

    // read data captured at the address phase edge
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            hrdata <= 32'h0;
        end else if (accept && !hwrite) begin
            hrdata <= 32'h0;
            if (haddr[31:8] == 24'h0) begin
                unique case (aOff)
                    OFF_CTRL_A:   hrdata[7:0] <= ctrlView(0);
                    OFF_CTRL_B:   hrdata[7:0] <= ctrlView(1);
                    OFF_EVT_STAT: hrdata[1:0] <= evtStat;
                    OFF_EVT_MASK: hrdata[1:0] <= evtMask;
                    default:      hrdata <= 32'h0;
                endcase
            end
        end
    end

    // ************************************************
    // control registers
    // ************************************************
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ctrl[0] <= CTRL_A_RST;
            ctrl[1] <= CTRL_B_RST;
        end else if (wrPend && (wrAddr == OFF_CTRL_A)) begin
            ctrl[0] <= hwdata[7:0] & CTRL_WR_MASK;
        end else if (wrPend && (wrAddr == OFF_CTRL_B)) begin
            ctrl[1] <= hwdata[7:0] & CTRL_WR_MASK;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            evtMask <= EVT_MASK_RST;
        end else if (wrPend && (wrAddr == OFF_EVT_MASK)) begin
            evtMask <= hwdata[1:0];
        end
    end

    // sticky events, read clears, a new event wins
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            evtStat <= 2'h0;
        end else begin
            evtStat <= (rdStat ? 2'h0 : evtStat) | evtHit;
        end
    end

    assign intLevel = |(evtStat & evtMask);

    // ************************************************
    // monitors
    // ************************************************
    logic [1:0] syncFirst;
    logic [1:0] active;
    logic [1:0] qual;
    logic [1:0] qualPrev;
    logic [1:0] rstHit;
    logic [DET_CNT_W-1:0] lowCnt [2];

    localparam logic [DET_CNT_W-1:0] CNT_LAST = DET_CNT_W'(DETECT_CYCLES - 1);

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_mon
            logic rise;
            logic fall;

            // two-stage synchroniser
            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    syncFirst[gi] <= 1'b0;
                    belowSync[gi] <= 1'b0;
                end else begin
                    syncFirst[gi] <= supplyBelowRaw[gi];
                    belowSync[gi] <= syncFirst[gi];
                end
            end

            assign active[gi] = ctrl[gi][BIT_ENABLE] &&
                codeValid(gi, ctrl[gi][BIT_CODE_HI:BIT_CODE_LO]);
            assign monitorEnable[gi] = active[gi];
            assign thresholdCode[gi*3 +: 3] = ctrl[gi][BIT_CODE_HI:BIT_CODE_LO];

            // low level must persist; release has no hold-off
            always_ff @(posedge ref_clk) begin
                if (sys_rst || !active[gi] || !belowSync[gi]) begin
                    lowCnt[gi] <= '0;
                    qual[gi] <= 1'b0;
                end else if (lowCnt[gi] == CNT_LAST) begin
                    qual[gi] <= 1'b1;
                end else begin
                    lowCnt[gi] <= lowCnt[gi] + 1'b1;
                end
            end

            always_ff @(posedge ref_clk) begin
                if (sys_rst) begin
                    qualPrev[gi] <= 1'b0;
                end else begin
                    qualPrev[gi] <= qual[gi];
                end
            end

            assign rise = qual[gi] && !qualPrev[gi];
            assign fall = !qual[gi] && qualPrev[gi] && active[gi];
            assign rstHit[gi] = qual[gi] && ctrl[gi][BIT_RST_ALLOW];
            assign evtHit[gi] = ctrl[gi][BIT_IRQ_ALLOW] && (rise ||
                (fall && irqEdgeChoice[gi] && !ctrl[gi][BIT_RST_ALLOW]));

            // ************************************************
            // checks per monitor
            // ************************************************
            sequence s_lowHeld;
                belowSync[gi] && active[gi];
            endsequence

            AST_STATUS_TRACKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
                ##2 belowSync[gi] == $past(supplyBelowRaw[gi], 2))
                else $error("status does not follow comparator");
            AST_RST_GATED: assert property (@(posedge ref_clk) disable iff (sys_rst)
                rstHit[gi] |-> ctrl[gi][BIT_RST_ALLOW] && ctrl[gi][BIT_ENABLE])
                else $error("reset request while not allowed");
            AST_IRQ_GATED: assert property (@(posedge ref_clk) disable iff (sys_rst)
                evtHit[gi] |-> ctrl[gi][BIT_IRQ_ALLOW])
                else $error("irq event while not allowed");
            AST_BOTH_EDGES: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (fall && irqEdgeChoice[gi] && ctrl[gi][BIT_IRQ_ALLOW] && !ctrl[gi][BIT_RST_ALLOW])
                |-> ##1 nmiUndervoltageIrq)
                else $error("rising supply crossing lost");
            AST_CHOICE_IDLE: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (fall && ctrl[gi][BIT_RST_ALLOW]) |-> !evtHit[gi])
                else $error("edge choice acted with reset allowed");
            AST_DISABLED_SILENT: assert property (@(posedge ref_clk) disable iff (sys_rst)
                !ctrl[gi][BIT_ENABLE] |-> ##1 !qual[gi])
                else $error("disabled monitor still detecting");
            AST_NO_HYST: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (qual[gi] && !belowSync[gi]) |=> !qual[gi])
                else $error("release held back");
            AST_DETECT_DELAY: assert property (@(posedge ref_clk) disable iff (sys_rst)
                $rose(qual[gi]) |-> $past(lowCnt[gi]) == CNT_LAST && $past(belowSync[gi] && active[gi]))
                else $error("detection before hold time");

            AST_COUNT_RUNS: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (s_lowHeld ##1 s_lowHeld) |-> (lowCnt[gi] == CNT_LAST) ||
                    (lowCnt[gi] == DET_CNT_W'($past(lowCnt[gi]) + 1'b1)))
                else $error("hold counter skipped or stalled");

            AST_RST_REACHES: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (qual[gi] && ctrl[gi][BIT_RST_ALLOW]) |-> resetReq)
                else $error("qualified low did not request reset");

            AST_RST_RELEASE: assert property (@(posedge ref_clk) disable iff (sys_rst)
                !active[gi] |=> !rstHit[gi])
                else $error("inactive monitor kept reset request");

            AST_FALL_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
                (fall && !irqEdgeChoice[gi]) |-> !evtHit[gi])
                else $error("release event with falling-only choice");
            AST_RESET_VALUE: assert property (@(posedge ref_clk)
                $past(sys_rst) |-> ctrl[gi] == ctrlRst(gi))
                else $error("control register reset value wrong");
        end
    endgenerate

    // ************************************************
    // system outputs
    // ************************************************
    assign resetReq = |rstHit;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            nmiUndervoltageIrq <= 1'b0;
        end else begin
            nmiUndervoltageIrq <= |evtHit;
        end
    end

    AST_UPPER_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
        hrdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_NMI_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (|evtHit) |=> nmiUndervoltageIrq)
        else $error("nmi request missed");
    AST_CODE_A: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (ctrl[0][BIT_CODE_HI:BIT_CODE_LO] != CODE_A_2V0 &&
         ctrl[0][BIT_CODE_HI:BIT_CODE_LO] != CODE_A_2V1) |-> !monitorEnable[0])
        else $error("reserved code active on monitor a");

    // ************************************************
    // bus and event checks
    // ************************************************
    sequence s_wrCtrlA;
        accept && hwrite && (haddr == 32'(OFF_CTRL_A)) ##1 1'b1;
    endsequence

    sequence s_wrCtrlB;
        accept && hwrite && (haddr == 32'(OFF_CTRL_B)) ##1 1'b1;
    endsequence

    sequence s_wrMask;
        accept && hwrite && (haddr == 32'(OFF_EVT_MASK)) ##1 1'b1;
    endsequence

    AST_WRITE_A: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_wrCtrlA |=> ctrl[0] == ($past(hwdata[7:0]) & CTRL_WR_MASK))
        else $error("write to control a lost");

    AST_WRITE_B: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_wrCtrlB |=> ctrl[1] == ($past(hwdata[7:0]) & CTRL_WR_MASK))
        else $error("write to control b lost");

    AST_MASK_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        s_wrMask |=> evtMask == $past(hwdata[1:0]))
        else $error("write to event mask lost");

    AST_READ_BELOW: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (accept && !hwrite && (haddr == 32'(OFF_CTRL_A))) |=> hrdata[BIT_BELOW] == $past(belowSync[0]))
        else $error("status bit read wrong");

    AST_READ_EDGE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (accept && !hwrite && (haddr == 32'(OFF_CTRL_B))) |=> hrdata[BIT_EDGE] == $past(irqEdgeChoice[1]))
        else $error("edge choice bit read wrong");

    AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (rdStat && (evtHit == 2'h0)) |=> evtStat == 2'h0)
        else $error("event status not cleared by read");

    AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (rdStat && (evtHit != 2'h0)) |=> (evtStat & $past(evtHit)) == $past(evtHit))
        else $error("event lost in clearing read");

    AST_STICKY: assert property (@(posedge ref_clk) disable iff (sys_rst)
        !rdStat |=> ($past(evtStat) & ~evtStat) == 2'h0)
        else $error("event status dropped without read");

    AST_MASK_BLOCKS: assert property (@(posedge ref_clk) disable iff (sys_rst)
        (evtMask == 2'h0) |-> !intLevel)
        else $error("masked event raised interrupt level");

    AST_NMI_CAUSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
        nmiUndervoltageIrq |-> $past(|evtHit))
        else $error("nmi pulse without event");

    AST_CODE_B: assert property (@(posedge ref_clk) disable iff (sys_rst)
        ctrl[1][BIT_ENABLE] |-> monitorEnable[1])
        else $error("valid code on monitor b inactive");

endmodule

// ===== tb/sumc_supply_model.sv
// comparator model standing in for the analog side of both monitors
// assumes supply levels in units of 10 mV and the design's threshold code port
`timescale 1ns/100ps
module sumc_supply_model (
    // supply levels
    input  wire logic [9:0] supplyA,
    input  wire logic [9:0] supplyB,
    // threshold selection from the design
    input  wire logic [5:0] thresholdCode,
    // comparator outputs, async levels
    output logic      [1:0] supplyBelowRaw
);
    logic [9:0] thrA;
    logic [9:0] thrB;

    always_comb begin
        // reserved codes of monitor a trip only at a zero supply level
        thrA = (thresholdCode[2:0] == 3'h4) ? 10'h0C8 : (thresholdCode[2:0] == 3'h5) ? 10'h0D2 : 10'h000;
        thrB = 10'h0DC + 10'(10 * thresholdCode[5:3]);
        // no hysteresis: output follows the level directly
        supplyBelowRaw = {supplyB <= thrB, supplyA <= thrA};
    end
endmodule

// ===== tb/supply_undervoltage_monitor_ctrl_test.sv
// self-checking bench for the two-channel undervoltage monitor
// assumes sumc_top, sumc_pkg and the comparator model are compiled first
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin miscompares++; $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module supply_undervoltage_monitor_ctrl_test;
    import sumc_pkg::*;
    localparam int DET = 8;
    logic        ref_clk   = 1'b0;
    logic        sys_rst   = 1'b1;
    logic        hsel      = 1'b0;
    logic [31:0] haddr     = 32'h0;
    logic [1:0]  htrans    = 2'h0;
    logic        hwrite    = 1'b0;
    logic [31:0] hwdata    = 32'h0;
    logic [1:0]  edgeSel   = 2'h1;
    logic [9:0]  supA      = 10'h14A;
    logic [9:0]  supB      = 10'h14A;
    logic        rdPhase   = 1'b0;
    logic        hreadyout, hresp, resetReq, nmi, intLevel;
    logic [31:0] hrdata;
    logic [1:0]  below, monEn;
    logic [5:0]  thrCode;
    logic [9:0]  thrB;
    logic [31:0] expQ[$];
    int          miscompares = 0, comparisons = 0, cycles = 0, nmiCount = 0;
    int unsigned c;

    always #2 ref_clk = ~ref_clk;

    sumc_top #(.DETECT_CYCLES(DET)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .supplyBelowRaw(below),
        .irqEdgeChoice(edgeSel), .monitorEnable(monEn), .thresholdCode(thrCode), .resetReq(resetReq),
        .nmiUndervoltageIrq(nmi), .intLevel(intLevel));

    sumc_supply_model model (.supplyA(supA), .supplyB(supB), .thresholdCode(thrCode), .supplyBelowRaw(below));

    task automatic print_verdict();
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // cycle count, pulse count and hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (nmi === 1'b1) nmiCount++;
        if (cycles > 5000) begin
            miscompares++;
            print_verdict();
        end
    end

    // read data checked at the edge that ends the data phase
    always @(posedge ref_clk) begin
        if (rdPhase && hreadyout === 1'b1) `CHK(hrdata, expQ.pop_front())
        if (rdPhase && hreadyout === 1'b1) `CHK(hresp, HRESP_OKAY)
    end

    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wr ? d : 32'h0;
        rdPhase <= !wr;
        if (!wr) expQ.push_back(d);
        do @(posedge ref_clk); while (hreadyout !== 1'b1 && ++n < 100);
        rdPhase <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    initial begin
        void'($urandom(32'h51d5));
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        `CHK(monEn, 2'b01)
        `CHK(thrCode, 6'h1C)
        bus(OFF_CTRL_A, 1'b0, 32'h59);
        bus(OFF_CTRL_B, 1'b0, 32'h06);
        bus(32'h10, 1'b0, 32'h0);
        // monitor a at exactly 2.0 V with reset allowed
        supA <= 10'h0C8;
        tick(DET / 2);
        `CHK(resetReq, 1'b0)
        tick(DET + 2);
        `CHK(resetReq, 1'b1)
        bus(OFF_CTRL_A, 1'b0, 32'hD9);
        `CHK(nmiCount, 0)
        supA <= 10'h0C9;
        tick(5);
        `CHK(resetReq, 1'b0)
        // disabled or reserved code stays silent
        supA <= 10'h0C8;
        bus(OFF_CTRL_A, 1'b1, {24'($urandom), 8'h48});
        tick(DET + 6);
        `CHK(resetReq, 1'b0)
        bus(OFF_CTRL_A, 1'b1, 32'h41);
        tick(DET + 6);
        `CHK(monEn[0], 1'b0)
        `CHK(resetReq, 1'b0)
        bus(OFF_CTRL_A, 1'b1, 32'h4B);
        tick(DET + 6);
        `CHK(resetReq, 1'b1)
        supA <= 10'h14A;
        // monitor b interrupt path, random threshold code
        c = $urandom % 8;
        thrB = 10'h0DC + 10'(10 * c);
        edgeSel <= 2'h3;
        bus(OFF_EVT_MASK, 1'b1, 32'h2);
        bus(OFF_CTRL_B, 1'b1, {24'($urandom), 8'h21 | 8'(c << 1)});
        bus(OFF_CTRL_B, 1'b0, 32'h31 | 32'(c << 1));
        supB <= thrB;
        tick(DET + 6);
        `CHK(nmiCount, 1)
        `CHK(intLevel, 1'b1)
        bus(OFF_EVT_STAT, 1'b0, 32'h2);
        tick(1);
        `CHK(intLevel, 1'b0)
        supB <= thrB + 10'h1;
        tick(8);
        `CHK(nmiCount, 2)
        edgeSel <= 2'h1;
        supB <= thrB;
        tick(DET + 6);
        supB <= thrB + 10'h1;
        tick(8);
        `CHK(nmiCount, 3)
        `CHK(resetReq, 1'b0)
        bus(OFF_EVT_MASK, 1'b1, 32'h0);
        tick(1);
        `CHK(intLevel, 1'b0)
        bus(OFF_EVT_STAT, 1'b0, 32'h2);
        // reset in mid-run restores both registers
        sys_rst <= 1'b1;
        tick(2);
        sys_rst <= 1'b0;
        tick(1);
        `CHK(intLevel, 1'b0)
        bus(OFF_CTRL_A, 1'b0, 32'h59);
        bus(OFF_CTRL_B, 1'b0, 32'h06);
        print_verdict();
    end
endmodule
